// file: verilog/quad_pkg.sv
// Shared constants and types of the quadrature position decoder
package quad_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] CAP1_OFFSET = 8'h04;
	localparam logic [7:0] CAP2_OFFSET = 8'h08;
	localparam logic [7:0] CAP3_OFFSET = 8'h0C;
	localparam logic [7:0] FLAG_OFFSET = 8'h10;
	localparam logic [7:0] AUX_OFFSET = 8'h14;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int VEL_DIS_BIT = 7;
	localparam int ERROR_BIT = 6;
	localparam int DIR_BIT = 5;
	localparam int FLAG_VEL_BIT = 0;
	localparam int FLAG_POS_BIT = 1;
	localparam int FLAG_DIR_BIT = 2;
	localparam int AUX_CAPEN_BIT = 0;
	localparam int AUX_POSIE_BIT = 1;
	localparam int AUX_CAPACT_BIT = 2;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] LIMIT_RESET = 16'hFFFF;
	localparam logic [2:0] FLAG_RESET = 3'h0;
	localparam logic [1:0] AUX_RESET = 2'h0;

	// ----------------------------------------------------------------
	// Bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Modes and types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_OFF = 3'b000,
		MODE_X2_INDEX = 3'b001,
		MODE_X2_LIMIT = 3'b010,
		MODE_UNUSED3 = 3'b011,
		MODE_UNUSED4 = 3'b100,
		MODE_X4_INDEX = 3'b101,
		MODE_X4_LIMIT = 3'b110,
		MODE_UNUSED7 = 3'b111
	} mode_type;

	typedef enum logic [1:0] {
		RATIO_1 = 2'b00,
		RATIO_4 = 2'b01,
		RATIO_16 = 2'b10,
		RATIO_64 = 2'b11
	} ratio_type;

	typedef struct packed {
		logic velocityDisableN;
		logic errorFlag;
		logic direction;
		mode_type encoderModeSelect;
		ratio_type pulseRatioSelect;
	} ctrl_type;

endpackage : quad_pkg

// file: verilog/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync
	import quad_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic pinIn,
	output logic level
);

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// A change is accepted only once stages two and three agree
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level <= 1'b0;
		end else if (ce) begin
			s1_reg <= pinIn;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level <= s3_reg;
			end
		end
	end

endmodule : pin_sync

// file: verilog/quadrature_position_decoder.sv
// Quadrature position decoder with AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
module quadrature_position_decoder
	import quad_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic phaseA,
	input wire logic phaseB,
	input wire logic indexInput,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic captureEnable,
	output logic [2:0] capturePins,
	output logic velocityPulse
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic [7:0] mergeByte(input logic [7:0] old,
		input logic [7:0] data, input logic en);
		mergeByte = en ? data : old;
	endfunction : mergeByte

	function automatic logic [5:0] ratioLast(input ratio_type r);
		unique case (r)
			RATIO_1: ratioLast = 6'd0;
			RATIO_4: ratioLast = 6'd3;
			RATIO_16: ratioLast = 6'd15;
			RATIO_64: ratioLast = 6'd63;
		endcase
	endfunction : ratioLast

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	ctrl_type ctrl_reg;
	logic [15:0] count_reg;
	logic [15:0] limit_reg;
	logic [15:0] velocity_reg;
	logic [2:0] flag_reg;
	logic [1:0] aux_reg;
	logic [5:0] scale_reg;
	logic prevA_reg;
	logic prevB_reg;
	logic prevIdx_reg;
	logic [7:0] awAddr_reg;
	logic awHeld_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic wHeld_reg;

	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	logic syncA;
	logic syncB;
	logic syncIdx;

	pin_sync syncPhaseA (.core_clk(core_clk), .rst(rst), .ce(ce),
		.pinIn(phaseA), .level(syncA));
	pin_sync syncPhaseB (.core_clk(core_clk), .rst(rst), .ce(ce),
		.pinIn(phaseB), .level(syncB));
	pin_sync syncIndex (.core_clk(core_clk), .rst(rst), .ce(ce),
		.pinIn(indexInput), .level(syncIdx));

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	logic encOn;
	logic x4Mode;
	logic indexMode;
	logic velOn;

	always_comb begin
		encOn = 1'b0;
		x4Mode = 1'b0;
		indexMode = 1'b0;
		unique case (ctrl_reg.encoderModeSelect)
			MODE_X2_INDEX: begin
				encOn = 1'b1;
				indexMode = 1'b1;
			end
			MODE_X2_LIMIT: encOn = 1'b1;
			MODE_X4_INDEX: begin
				encOn = 1'b1;
				x4Mode = 1'b1;
				indexMode = 1'b1;
			end
			MODE_X4_LIMIT: begin
				encOn = 1'b1;
				x4Mode = 1'b1;
			end
			default: encOn = 1'b0;
		endcase
	end

	assign velOn = encOn && !ctrl_reg.velocityDisableN;

	// Encoder takes the shared pins whenever a mode is on
	assign captureEnable = aux_reg[AUX_CAPEN_BIT] && !encOn;
	assign capturePins = captureEnable ? {syncIdx, syncB, syncA} :
		3'b000;

	// ----------------------------------------------------------------
	// Edge and direction decode
	// ----------------------------------------------------------------
	logic edgeA;
	logic edgeB;
	logic step;
	logic stepUp;
	logic idxRise;
	logic idxFall;

	assign edgeA = syncA ^ prevA_reg;
	assign edgeB = syncB ^ prevB_reg;
	assign idxRise = syncIdx && !prevIdx_reg;
	assign idxFall = !syncIdx && prevIdx_reg;

	// Two edges in one sample are ambiguous, so they are dropped
	always_comb begin
		step = 1'b0;
		stepUp = 1'b0;
		if (encOn && edgeA && !edgeB) begin
			step = 1'b1;
			stepUp = syncA ^ syncB;
		end else if (encOn && x4Mode && edgeB && !edgeA) begin
			step = 1'b1;
			stepUp = syncA ~^ syncB;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			prevA_reg <= 1'b0;
			prevB_reg <= 1'b0;
			prevIdx_reg <= 1'b0;
		end else if (ce) begin
			prevA_reg <= syncA;
			prevB_reg <= syncB;
			prevIdx_reg <= syncIdx;
		end
	end

	// ----------------------------------------------------------------
	// Bus write capture
	// ----------------------------------------------------------------
	logic doWrite;
	logic [7:0] wAddr;

	assign s_axi_awready = !awHeld_reg;
	assign s_axi_wready = !wHeld_reg;
	assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
	assign wAddr = awAddr_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= s_axi_awaddr;
			end else if (doWrite) begin
				awHeld_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end else if (doWrite) begin
				wHeld_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (ce) begin
			if (doWrite) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wAddr[1:0] == 2'b00 && wAddr <= AUX_OFFSET)
					? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	logic wrCtrl;
	logic wrCap1;
	logic wrCap2;
	logic wrCap3;
	logic wrFlag;
	logic wrAux;

	assign wrCtrl = doWrite && wAddr == CTRL_OFFSET && wStrb_reg[0];
	assign wrCap1 = doWrite && wAddr == CAP1_OFFSET;
	assign wrCap2 = doWrite && wAddr == CAP2_OFFSET;
	assign wrCap3 = doWrite && wAddr == CAP3_OFFSET;
	assign wrFlag = doWrite && wAddr == FLAG_OFFSET && wStrb_reg[0];
	assign wrAux = doWrite && wAddr == AUX_OFFSET && wStrb_reg[0];

	// ----------------------------------------------------------------
	// Position counter
	// ----------------------------------------------------------------
	logic posReset;
	logic wrapError;
	logic [15:0] countNext;

	always_comb begin
		countNext = count_reg;
		posReset = 1'b0;
		wrapError = 1'b0;
		if (indexMode && idxRise && ctrl_reg.direction) begin
			countNext = COUNT_RESET;
			posReset = 1'b1;
		end else if (indexMode && idxFall && !ctrl_reg.direction) begin
			countNext = limit_reg;
			posReset = 1'b1;
		end else if (step && !indexMode && stepUp &&
			count_reg == limit_reg) begin
			countNext = COUNT_RESET;
			posReset = 1'b1;
		end else if (step && !indexMode && !stepUp &&
			count_reg == COUNT_RESET) begin
			countNext = limit_reg;
			posReset = 1'b1;
		end else if (step) begin
			countNext = stepUp ? count_reg + 16'h0001 :
				count_reg - 16'h0001;
			wrapError = indexMode && (stepUp ? &count_reg :
				~|count_reg);
		end
	end

	// Software writes to the count win over a same-cycle step
	always_ff @(posedge core_clk) begin
		if (rst) begin
			count_reg <= COUNT_RESET;
		end else if (ce) begin
			if (wrCap2) begin
				count_reg[7:0] <= mergeByte(count_reg[7:0],
					wData_reg[7:0], wStrb_reg[0]);
				count_reg[15:8] <= mergeByte(count_reg[15:8],
					wData_reg[15:8], wStrb_reg[1]);
			end else begin
				count_reg <= countNext;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			limit_reg <= LIMIT_RESET;
		end else if (ce && wrCap3) begin
			limit_reg[7:0] <= mergeByte(limit_reg[7:0],
				wData_reg[7:0], wStrb_reg[0]);
			limit_reg[15:8] <= mergeByte(limit_reg[15:8],
				wData_reg[15:8], wStrb_reg[1]);
		end
	end

	// ----------------------------------------------------------------
	// Control register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_reg <= ctrl_type'(CTRL_RESET);
		end else if (ce) begin
			if (wrCtrl) begin
				ctrl_reg.velocityDisableN <= wData_reg[VEL_DIS_BIT];
				ctrl_reg.encoderModeSelect <= mode_type'(wData_reg[4:2]);
				ctrl_reg.pulseRatioSelect <= ratio_type'(wData_reg[1:0]);
			end
			if (step) begin
				ctrl_reg.direction <= stepUp;
			end
			if (wrapError) begin
				ctrl_reg.errorFlag <= 1'b1;
			end else if (wrCtrl) begin
				ctrl_reg.errorFlag <= wData_reg[ERROR_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Velocity postscaler
	// ----------------------------------------------------------------
	logic velIn;
	logic scaleDone;

	assign velIn = velOn && step;
	assign scaleDone = velIn &&
		scale_reg == ratioLast(ctrl_reg.pulseRatioSelect);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			scale_reg <= 6'd0;
			velocityPulse <= 1'b0;
		end else if (ce) begin
			velocityPulse <= scaleDone;
			if (!velOn || scaleDone) begin
				scale_reg <= 6'd0;
			end else if (velIn) begin
				scale_reg <= scale_reg + 6'd1;
			end
		end
	end

	// Counts postscaler outputs; a software write loads it with the written value
	always_ff @(posedge core_clk) begin
		if (rst) begin
			velocity_reg <= COUNT_RESET;
		end else if (ce) begin
			if (wrCap1) begin
				velocity_reg <= wData_reg[15:0];
			end else if (scaleDone) begin
				velocity_reg <= velocity_reg + 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Event flags and auxiliary control
	// ----------------------------------------------------------------
	logic [2:0] flagSet;

	assign flagSet[FLAG_VEL_BIT] = scaleDone;
	assign flagSet[FLAG_POS_BIT] = posReset &&
		aux_reg[AUX_POSIE_BIT];
	assign flagSet[FLAG_DIR_BIT] = step &&
		stepUp != ctrl_reg.direction;

	// Write one to clear; a same-cycle set is kept
	always_ff @(posedge core_clk) begin
		if (rst) begin
			flag_reg <= FLAG_RESET;
		end else if (ce) begin
			flag_reg <= (flag_reg & ~(wrFlag ? wData_reg[2:0] : 3'b000))
				| flagSet;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			aux_reg <= AUX_RESET;
		end else if (ce && wrAux) begin
			aux_reg <= wData_reg[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Bus read
	// ----------------------------------------------------------------
	logic [31:0] readWord;
	logic readOk;

	always_comb begin
		readWord = 32'h0000_0000;
		readOk = 1'b1;
		unique case (s_axi_araddr)
			CTRL_OFFSET: readWord[7:0] = ctrl_reg;
			CAP1_OFFSET: readWord[15:0] = encOn ? velocity_reg :
				16'h0000;
			CAP2_OFFSET: readWord[15:0] = encOn ? count_reg :
				16'h0000;
			CAP3_OFFSET: readWord[15:0] = encOn ? limit_reg :
				16'h0000;
			FLAG_OFFSET: readWord[2:0] = flag_reg;
			AUX_OFFSET: readWord[2:0] = {captureEnable, aux_reg};
			default: readOk = 1'b0;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= readWord;
				s_axi_rresp <= readOk ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule : quadrature_position_decoder

// file: test/quad_encoder.sv
// Behavioural incremental encoder with an index output
`timescale 1ns/1ns
module quad_encoder (
	input wire logic core_clk,
	input wire logic stepReq,
	input wire logic stepDir,
	input wire logic indexReq,
	output logic phaseA,
	output logic phaseB,
	output logic indexOut
);
	// Quarter-turn position; forward travel makes phase_a lead phase_b
	logic [1:0] pos_reg = 2'b00;
	always_ff @(posedge core_clk) begin
		if (stepReq)
			pos_reg <= stepDir ? pos_reg + 2'b01 : pos_reg - 2'b01;
		indexOut <= indexReq;
	end
	assign phaseA = pos_reg[1] ^ pos_reg[0];
	assign phaseB = pos_reg[1];
endmodule : quad_encoder

// file: test/quadrature_position_decoder_assertions.sv
// Port-level checks of the quadrature position decoder
`timescale 1ns/1ns
module quadrature_position_decoder_assertions
	import quad_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic phaseA,
	input wire logic phaseB,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic captureEnable,
	input wire logic [2:0] capturePins,
	input wire logic velocityPulse
);
	// ------------------------------------------------------------
	// Quiet spell counter
	// ------------------------------------------------------------
	// Velocity pulses trail a pin edge by several cycles, so only a
	// long quiet spell proves that none may appear; frozen cycles
	// do not count, since the pin path holds while enable is low
	logic [1:0] pins_reg;
	logic [3:0] quiet_reg;
	always_ff @(posedge core_clk) begin
		pins_reg <= {phaseB, phaseA};
		if (rst || pins_reg != {phaseB, phaseA})
			quiet_reg <= 4'h0;
		else if (ce && quiet_reg != 4'hF)
			quiet_reg <= quiet_reg + 4'h1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	bresp_hold_a: assert property (ce && s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
	rdata_hold_a: assert property (ce && s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
	read_answer_a: assert property (ce && s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid || !ce) else $error("read not answered");
	read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while read pending");
	write_answer_a: assert property (ce && s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready ##1 ce |=> s_axi_bvalid)
		else $error("write not answered");
	pins_gated_a: assert property (
		!captureEnable |-> capturePins == 3'b000)
		else $error("capture pins leak while owned by decoder");
	vel_quiet_a: assert property (
		quiet_reg >= 4'h8 |-> !velocityPulse)
		else $error("velocity pulse without pin edge");
	vel_single_a: assert property (
		velocityPulse |=> !velocityPulse)
		else $error("velocity pulse wider than one cycle");
endmodule : quadrature_position_decoder_assertions

bind quadrature_position_decoder quadrature_position_decoder_assertions
	chk_u (.core_clk(core_clk), .rst(rst), .ce(ce), .phaseA(phaseA),
	.phaseB(phaseB), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .captureEnable(captureEnable),
	.capturePins(capturePins), .velocityPulse(velocityPulse));

// file: test/tb.sv
// Self-checking bench for the quadrature position decoder
`timescale 1ns/1ns
module tb import quad_pkg::*;;
	typedef struct {
		logic [7:0] ctrl;
		logic dir;
		int steps;
		logic [15:0] cnt;
		int vel;
	} row_type;
	logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1;
	logic stepReq = 1'b0, stepDir = 1'b1, indexReq = 1'b0;
	logic phaseA, phaseB, indexInput, captureEnable, velocityPulse;
	logic [2:0] capturePins;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [31:0] s_axi_rdata, got;
	int fails = 0, nTests = 0, velCnt = 0, velBase;
	row_type rows [10] = '{
		'{8'h14, 1'b1, 4, 16'h0104, 4}, '{8'h08, 1'b1, 4, 16'h0102, 2},
		'{8'h19, 1'b0, 8, 16'h00F8, 2}, '{8'h16, 1'b1, 16, 16'h0110, 1},
		'{8'h17, 1'b1, 64, 16'h0140, 1}, '{8'h84, 1'b1, 4, 16'h0102, 0},
		'{8'h0C, 1'b1, 4, 16'h0000, 0}, '{8'h10, 1'b1, 4, 16'h0000, 0},
		'{8'h1C, 1'b1, 4, 16'h0000, 0}, '{8'h00, 1'b1, 4, 16'h0000, 0}
	};
	initial forever #2 core_clk = ~core_clk;
	always @(posedge core_clk)
		if (velocityPulse === 1'b1)
			velCnt <= velCnt + 1;
	quad_encoder enc_u (.core_clk(core_clk), .stepReq(stepReq),
		.stepDir(stepDir), .indexReq(indexReq), .phaseA(phaseA),
		.phaseB(phaseB), .indexOut(indexInput));
	quadrature_position_decoder dut_u (.core_clk(core_clk), .rst(rst),
		.ce(ce), .phaseA(phaseA), .phaseB(phaseB), .indexInput(indexInput),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .captureEnable(captureEnable),
		.capturePins(capturePins), .velocityPulse(velocityPulse));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic report_and_stop;
		$display("Checks %0d, errors %0d", nTests, fails);
		if (fails == 0 && nTests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		nTests++;
		if (g !== e) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	// One transfer; ready is sampled before the edge that takes it
	task automatic bus(input logic isWr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
		int n;
		logic b;
		logic [2:0] hs;
		n = 0;
		b = 1'b0;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= isWr;
		s_axi_wvalid <= isWr;
		s_axi_bready <= isWr;
		s_axi_arvalid <= !isWr;
		s_axi_rready <= !isWr;
		while (!b && n < 40) begin
			@(negedge core_clk);
			hs[2] = s_axi_awvalid && s_axi_awready === 1'b1;
			hs[1] = s_axi_wvalid && s_axi_wready === 1'b1;
			hs[0] = s_axi_arvalid && s_axi_arready === 1'b1;
			b = isWr ? s_axi_bvalid === 1'b1 : s_axi_rvalid === 1'b1;
			r = isWr ? s_axi_bresp : s_axi_rresp;
			q = s_axi_rdata;
			@(posedge core_clk);
			if (hs[2])
				s_axi_awvalid <= 1'b0;
			if (hs[1])
				s_axi_wvalid <= 1'b0;
			if (hs[0])
				s_axi_arvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		// One edge between transfers, so no ready is assigned twice
		@(posedge core_clk);
		if (!b) begin
			fails++;
			$display("Error at %0t: bus timeout", $time);
			report_and_stop;
		end
	endtask : bus
	// Steps stay nine cycles apart, above the decoder's pin filter
	task automatic step(input logic dir, input int n);
		repeat (n) begin
			stepDir <= dir;
			stepReq <= 1'b1;
			@(posedge core_clk);
			stepReq <= 1'b0;
			repeat (8) @(posedge core_clk);
		end
	endtask : step
	task automatic pulse_index;
		indexReq <= 1'b1;
		repeat (8) @(posedge core_clk);
		indexReq <= 1'b0;
		repeat (8) @(posedge core_clk);
	endtask : pulse_index
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		for (int i = 0; i < 10; i++) begin
			bus(1'b1, CTRL_OFFSET, {24'h0, rows[i].ctrl}, got, resp);
			bus(1'b1, CAP2_OFFSET, 32'h0000_0100, got, resp);
			velBase = velCnt;
			step(rows[i].dir, rows[i].steps);
			bus(1'b0, CAP2_OFFSET, 32'h0, got, resp);
			chk(got, {16'h0, rows[i].cnt});
			chk(velCnt - velBase, rows[i].vel);
			bus(1'b0, CTRL_OFFSET, 32'h0, got, resp);
			if (rows[i].cnt != 16'h0000)
				chk(got[DIR_BIT], rows[i].dir);
		end
		bus(1'b1, CTRL_OFFSET, 32'h0000_0014, got, resp);
		bus(1'b0, CAP2_OFFSET, 32'h0, got, resp);
		chk(got, 32'h0000_0100);
		bus(1'b0, CAP1_OFFSET, 32'h0, got, resp);
		chk(got, 32'h0000_000A);
		bus(1'b1, AUX_OFFSET, 32'h0000_0002, got, resp);
		bus(1'b1, FLAG_OFFSET, 32'h0000_0007, got, resp);
		bus(1'b1, CTRL_OFFSET, 32'h0000_0018, got, resp);
		bus(1'b1, CAP3_OFFSET, 32'h0000_0003, got, resp);
		bus(1'b1, CAP2_OFFSET, 32'h0000_0002, got, resp);
		step(1'b1, 2);
		bus(1'b0, CAP2_OFFSET, 32'h0, got, resp);
		chk(got, 32'h0000_0000);
		step(1'b0, 1);
		bus(1'b0, CAP2_OFFSET, 32'h0, got, resp);
		chk(got, 32'h0000_0003);
		bus(1'b0, FLAG_OFFSET, 32'h0, got, resp);
		chk(got[2:0], 3'b111);
		bus(1'b1, FLAG_OFFSET, 32'h0000_0006, got, resp);
		bus(1'b0, FLAG_OFFSET, 32'h0, got, resp);
		chk(got[2:1], 2'b00);
		bus(1'b1, CTRL_OFFSET, 32'h0000_0014, got, resp);
		bus(1'b0, CAP2_OFFSET, 32'h0, got, resp);
		chk(got, 32'h0000_0003);
		bus(1'b1, CAP2_OFFSET, 32'h0000_FFFF, got, resp);
		step(1'b1, 1);
		bus(1'b0, CTRL_OFFSET, 32'h0, got, resp);
		chk(got[7:5], 3'b011);
		bus(1'b1, CTRL_OFFSET, 32'h0000_0014, got, resp);
		bus(1'b0, CTRL_OFFSET, 32'h0, got, resp);
		chk(got[ERROR_BIT], 1'b0);
		step(1'b1, 2);
		pulse_index();
		bus(1'b0, CAP2_OFFSET, 32'h0, got, resp);
		chk(got, 32'h0000_0000);
		bus(1'b1, CAP2_OFFSET, 32'h0000_0005, got, resp);
		step(1'b0, 1);
		pulse_index();
		bus(1'b0, CAP2_OFFSET, 32'h0, got, resp);
		chk(got, 32'h0000_0003);
		bus(1'b1, AUX_OFFSET, 32'h0000_0001, got, resp);
		chk(captureEnable, 1'b0);
		bus(1'b1, CTRL_OFFSET, 32'h0000_0020, got, resp);
		bus(1'b0, CTRL_OFFSET, 32'h0, got, resp);
		chk(got, 32'h0000_0000);
		chk(captureEnable, 1'b1);
		chk(capturePins, {indexInput, phaseB, phaseA});
		bus(1'b1, 8'h18, 32'h0000_0001, got, resp);
		chk(resp, RESP_SLVERR);
		bus(1'b0, 8'h18, 32'h0, got, resp);
		chk({got[1:0], resp}, {2'b00, RESP_SLVERR});
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		chk(captureEnable, 1'b0);
		bus(1'b0, CTRL_OFFSET, 32'h0, got, resp);
		chk(got, {24'h0, CTRL_RESET});
		bus(1'b0, AUX_OFFSET, 32'h0, got, resp);
		chk(got, 32'h0000_0000);
		bus(1'b1, CTRL_OFFSET, 32'h0000_0014, got, resp);
		bus(1'b0, CAP3_OFFSET, 32'h0, got, resp);
		chk(got, {16'h0, LIMIT_RESET});
		bus(1'b0, CAP2_OFFSET, 32'h0, got, resp);
		chk(got, {16'h0, COUNT_RESET});
		// Enable low holds the pin path, so the count lags the pins
		ce <= 1'b0;
		step(1'b1, 1);
		ce <= 1'b1;
		bus(1'b0, CAP2_OFFSET, 32'h0, got, resp);
		chk(got, {16'h0, COUNT_RESET});
		repeat (8) @(posedge core_clk);
		bus(1'b0, CAP2_OFFSET, 32'h0, got, resp);
		chk(got, 32'h0000_0001);
		report_and_stop;
	end
endmodule : tb
